// ==== hw/wwdt_consts.vh ====
// Constants for the windowed watchdog timer
// Notes on behaviour
// (R1) Key write clears counter, counting restarts
// (R2) Non-key value written causes internal reset
// (R3) Single-bit access to service register resets
// (R4) Illegal access waits for running source clock
// (R5) Reads return fixed reset value, never key
// (R6) Reset value 1AH if run off, 9AH on
// (R7) Run option enables counting and access checks
// (R8) Overflow period is two to (10+n) ticks
// (R9) Counter reaching overflow causes internal reset
// (R10) Window field selects 25/50/75/100 percent open
// (R11) Key in open window clears, no reset
// (R12) Key in closed window causes internal reset
// (R13) First write after reset ignores window
// (R14) Shortest overflow with 25 percent prohibited
// (R15) Lock bit keeps counting in halt, stop
// (R16) Unlocked counter resumes held value after halt
// (R17) Unlocked oscillator stop halts, keeps count
// (R18) Counting continues during flash self-programming
// (R19) Watchdog reset sets cause flag bit 4
// (R20) Counter ticks on low-speed oscillator clock
// (R21) Closed part first, open part ends period
`ifndef WWDT_CONSTS_VH
`define WWDT_CONSTS_VH

`define WWDT_SVC_ADDR     16'hFF99
`define WWDT_KEY          8'hAC
`define WWDT_RD_RUN       8'h9A
`define WWDT_RD_NORUN     8'h1A
`define WWDT_RD_NONE      8'h00

`define WWDT_OPT_LOCK     0
`define WWDT_OPT_OVF_LO   1
`define WWDT_OPT_OVF_HI   3
`define WWDT_OPT_RUN      4
`define WWDT_OPT_WIN_LO   5
`define WWDT_OPT_WIN_HI   6
`define WWDT_OSC_STOP_BIT 1
`define WWDT_CAUSE_BIT    4

`define WWDT_OVF_BASE     5'd10
`define WWDT_CNT_W        17
`define WWDT_LIM_W        18
`define WWDT_CNT_ZERO     17'h0_0000
`define WWDT_WIN_QUARTERS 2'd3

`endif

// ==== hw/wwdt_core.v ====
// Windowed watchdog timer core with service register and reset cause flag
`timescale 1ns/10ps
`include "wwdt_consts.vh"

module wwdt_core
(
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  input  wire        cause_por_n_i,
  input  wire        lowspeed_clk_i,
  input  wire [7:0]  option_byte_i,
  input  wire [7:0]  internal_osc_mode_reg_i,
  input  wire        halt_mode_i,
  input  wire        stop_mode_i,
  input  wire [15:0] bus_addr_i,
  input  wire        bus_wr_i,
  input  wire        bus_rd_i,
  input  wire        bus_bit_op_i,
  input  wire [7:0]  bus_wdata_i,
  input  wire        cause_clr_i,
  output wire [7:0]  bus_rdata_o,
  output wire        wdt_reset_o,
  output wire [7:0]  reset_cause_reg_o,
  output wire [16:0] wdt_count_o,
  output wire        window_open_o,
  output wire        wdt_running_o
);

  //////////////////////////////////////////////////////////////////////////////
  // States and helpers

  localparam [1:0] ST_INIT = 2'b00;
  localparam [1:0] ST_OFF  = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;
  localparam [1:0] ST_TRIP = 2'b11;

  // Overflow count for a 3-bit select field
  function [`WWDT_LIM_W-1:0] ovf_limit;
    input [2:0] sel;
    reg   [4:0] shift;
    begin
      shift     = `WWDT_OVF_BASE + {2'b00, sel};
      ovf_limit = {{(`WWDT_LIM_W-1){1'b0}}, 1'b1} << shift;
    end
  endfunction

  // Count below which the window is still closed
  function [`WWDT_LIM_W-1:0] close_thr;
    input [`WWDT_LIM_W-1:0] lim;
    input [1:0]             win;
    reg   [1:0]             quarters;
    begin
      quarters  = `WWDT_WIN_QUARTERS - win;
      close_thr = (lim >> 2) * {{(`WWDT_LIM_W-2){1'b0}}, quarters};
    end
  endfunction

  // Window still shut for this count
  function win_shut;
    input [`WWDT_CNT_W-1:0] cnt;
    input [`WWDT_LIM_W-1:0] lim_thr;
    begin
      win_shut = ({1'b0, cnt} < lim_thr);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [7:0]             opt_q;
  reg  [7:0]             svc_val_q;
  reg  [1:0]             state_q;
  reg  [1:0]             state_d;
  reg  [`WWDT_CNT_W-1:0] cnt_q;
  reg  [`WWDT_CNT_W-1:0] cnt_d;
  reg                    first_done_q;
  reg                    first_done_d;
  reg                    pend_q;
  reg                    pend_d;
  reg                    cause_q;
  reg  [7:0]             rdata_q;
  reg                    ls_s1_q;
  reg                    ls_s2_q;
  reg                    ls_s3_q;
  reg                    trip_q;
  reg                    open_q;
  reg                    run_q;

  wire                   run_en;
  wire                   osc_lock;
  wire [2:0]             ovf_sel;
  wire [1:0]             win_sel;
  wire                   osc_stop;
  wire                   ls_tick;
  wire                   src_run;
  wire                   cnt_run;
  wire [`WWDT_LIM_W-1:0] limit;
  wire [`WWDT_LIM_W-1:0] thr;
  wire [`WWDT_LIM_W-1:0] cnt_ext;
  wire                   win_closed;
  wire                   svc_hit;
  wire                   wr8;
  wire                   bit_op;
  wire                   key_ok;
  wire                   bad_val;
  wire                   early_key;
  wire                   abnormal;
  wire                   service;
  wire                   at_top;
  wire                   overflow;
  wire                   trip_evt;
  wire                   in_run;
  wire                   closed_nx;
  wire                   next_run;

  //////////////////////////////////////////////////////////////////////////////
  // Option byte, caught while reset is held

  assign run_en   = opt_q[`WWDT_OPT_RUN];
  assign osc_lock = opt_q[`WWDT_OPT_LOCK];
  assign ovf_sel  = opt_q[`WWDT_OPT_OVF_HI:`WWDT_OPT_OVF_LO];
  assign win_sel  = opt_q[`WWDT_OPT_WIN_HI:`WWDT_OPT_WIN_LO];
  assign osc_stop = internal_osc_mode_reg_i[`WWDT_OSC_STOP_BIT];

  // Prohibited 000/00 setting is not guarded; window then opens late
  always @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      opt_q <= option_byte_i;
    end
  end

  // Fixed readback value, chosen by the run option at reset
  always @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      svc_val_q <= option_byte_i[`WWDT_OPT_RUN] ? `WWDT_RD_RUN : `WWDT_RD_NORUN; // R6
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Low-speed clock: synchronised, rising edge becomes a tick
  // Chain preset high: release never fakes a rising edge

  always @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      ls_s1_q <= 1'b1;
      ls_s2_q <= 1'b1;
      ls_s3_q <= 1'b1;
    end
    else
    begin
      ls_s1_q <= lowspeed_clk_i;
      ls_s2_q <= ls_s1_q;
      ls_s3_q <= ls_s2_q;
    end
  end

  assign ls_tick = ls_s2_q & ~ls_s3_q; // R20

  // Unlocked oscillator may be stopped by software
  assign src_run = osc_lock | ~osc_stop; // R17

  // Self-programming has no input here: counting never pauses for it
  assign cnt_run = run_en & (osc_lock | ~(halt_mode_i | stop_mode_i | osc_stop)); // R15 R18

  //////////////////////////////////////////////////////////////////////////////
  // Window and overflow

  assign limit      = ovf_limit(ovf_sel); // R8
  assign thr        = close_thr(limit, win_sel); // R10
  assign cnt_ext    = {1'b0, cnt_q};
  assign win_closed = win_shut(cnt_q, thr); // R21
  assign at_top     = (cnt_ext == (limit - {{(`WWDT_LIM_W-1){1'b0}}, 1'b1}));
  assign closed_nx  = win_shut(cnt_d, thr);
  assign next_run   = (state_d == ST_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // Service register access decode

  assign svc_hit   = (bus_addr_i == `WWDT_SVC_ADDR);
  assign wr8       = svc_hit & bus_wr_i & ~bus_bit_op_i;
  assign bit_op    = svc_hit & bus_bit_op_i & (bus_wr_i | bus_rd_i); // R3
  assign key_ok    = wr8 & (bus_wdata_i == `WWDT_KEY);
  assign bad_val   = wr8 & (bus_wdata_i != `WWDT_KEY); // R2
  assign early_key = key_ok & win_closed & first_done_q; // R12

  // Checks live only in the running state
  assign in_run    = (state_q == ST_RUN);
  assign abnormal  = in_run & (bad_val | bit_op | early_key); // R7
  assign service   = in_run & key_ok & (~win_closed | ~first_done_q); // R11 R13
  assign overflow  = cnt_run & ls_tick & at_top & ~service; // R9

  //////////////////////////////////////////////////////////////////////////////
  // Control state machine

  always @*
  begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    first_done_d = first_done_q;
    pend_d       = pend_q;
    case (state_q)
      ST_INIT:
      begin
        state_d = run_en ? ST_RUN : ST_OFF; // R7
      end
      ST_OFF:
      begin
        state_d = ST_OFF;
      end
      ST_RUN:
      begin
        if (service)
        begin
          cnt_d        = `WWDT_CNT_ZERO; // R1
          first_done_d = 1'b1;
        end
        else if (cnt_run && ls_tick)
        begin
          cnt_d = cnt_q + {{(`WWDT_CNT_W-1){1'b0}}, 1'b1};
        end
        // Count is held, not cleared, whenever counting pauses
        if (wr8)
        begin
          first_done_d = 1'b1;
        end
        if (abnormal && !src_run)
        begin
          pend_d = 1'b1; // R4
        end
        if (overflow || (src_run && (abnormal || pend_q)))
        begin
          state_d = ST_TRIP; // R4
          pend_d  = 1'b0;
        end
      end
      ST_TRIP:
      begin
        state_d = ST_TRIP;
      end
      default:
      begin
        state_d = ST_INIT;
      end
    endcase
  end

  // Resume from the held value after halt or stop
  always @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q      <= ST_INIT;
      cnt_q        <= `WWDT_CNT_ZERO;
      first_done_q <= 1'b0;
      pend_q       <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      cnt_q        <= cnt_d; // R16
      first_done_q <= first_done_d;
      pend_q       <= pend_d;
    end
  end

  assign trip_evt = in_run & (state_d == ST_TRIP);

  //////////////////////////////////////////////////////////////////////////////
  // Reset cause flag, kept across the watchdog reset itself

  always @(posedge core_clk_i)
  begin
    if (!cause_por_n_i)
    begin
      cause_q <= 1'b0;
    end
    else if (trip_evt)
    begin
      cause_q <= 1'b1; // R19
    end
    else if (cause_clr_i)
    begin
      cause_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path: fixed value, never what software wrote

  always @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_q <= `WWDT_RD_NONE;
    end
    else if (bus_rd_i && svc_hit && !bus_bit_op_i)
    begin
      rdata_q <= svc_val_q; // R5
    end
    else
    begin
      rdata_q <= `WWDT_RD_NONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags taken from the next state, so they move with it

  always @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      trip_q <= 1'b0;
      open_q <= 1'b0;
      run_q  <= 1'b0;
    end
    else
    begin
      // Running flag trails the halt and stop inputs by a cycle
      trip_q <= (state_d == ST_TRIP);
      open_q <= next_run & ~closed_nx; // R21
      run_q  <= next_run & cnt_run;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus_rdata_o       = rdata_q;
  assign wdt_reset_o       = trip_q;
  assign reset_cause_reg_o = {3'b000, cause_q, 4'b0000};
  assign wdt_count_o       = cnt_q;
  assign window_open_o     = open_q;
  assign wdt_running_o     = run_q;

endmodule // wwdt_core

// ==== test/wwdt_core_monitor.sv ====
// Assertion checker for the windowed watchdog core
`timescale 1ns/10ps
module wwdt_core_monitor
(
  input wire        core_clk_i,
  input wire        reset_n_i,
  input wire [7:0]  option_byte_i,
  input wire [7:0]  internal_osc_mode_reg_i,
  input wire [15:0] bus_addr_i,
  input wire        bus_wr_i,
  input wire        bus_bit_op_i,
  input wire [7:0]  bus_wdata_i,
  input wire        wdt_reset_o,
  input wire [7:0]  reset_cause_reg_o,
  input wire [16:0] wdt_count_o,
  input wire        window_open_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire        run = option_byte_i[4];
  wire        wr  = bus_addr_i == 16'hFF99 && bus_wr_i && run;
  wire        w8  = wr && !bus_bit_op_i;
  wire        key = w8 && bus_wdata_i == 8'hAC;
  // Stopped source clock defers an illegal-access reset
  wire        stp = !option_byte_i[0] && internal_osc_mode_reg_i[1];
  wire [17:0] lim = 18'h0_0001 << (5'hA + option_byte_i[3:1]);
  wire [17:0] thr = (lim >> 2) * (2'h3 - option_byte_i[6:5]);
  reg         seen_q;
  ////////////////////////////////////////
  always @(posedge core_clk_i)
    seen_q <= reset_n_i && (seen_q || w8);
  property p_bad; w8 && bus_wdata_i != 8'hAC && !stp |=> wdt_reset_o; endproperty
  a_bad: assert property (p_bad) else $error("no reset on bad value");
  property p_bit; wr && bus_bit_op_i && !stp |=> wdt_reset_o; endproperty
  a_bit: assert property (p_bit) else $error("no reset on bit access");
  property p_stp; stp [*2] |-> !$rose(wdt_reset_o); endproperty
  a_stp: assert property (p_stp) else $error("reset while clock stopped");
  property p_key;
    key && (window_open_o || !seen_q) && !wdt_reset_o |=> !wdt_reset_o && wdt_count_o == 17'h0_0000;
  endproperty
  a_key: assert property (p_key) else $error("service did not clear");
  property p_shut; key && !window_open_o && seen_q && !stp |=> wdt_reset_o; endproperty
  a_shut: assert property (p_shut) else $error("closed key gave no reset");
  property p_cause; wdt_reset_o |-> reset_cause_reg_o[4] ##1 wdt_reset_o; endproperty
  a_cause: assert property (p_cause) else $error("cause flag or hold lost");
  property p_lim; !wdt_reset_o |-> {1'b0, wdt_count_o} < lim; endproperty
  a_lim: assert property (p_lim) else $error("count passed overflow");
  property p_win;
    run && !wdt_reset_o && $past(reset_n_i) |-> window_open_o == ({1'b0, wdt_count_o} >= thr);
  endproperty
  a_win: assert property (p_win) else $error("window edge wrong");
  property p_off; !run |-> wdt_count_o == 17'h0_0000 && !wdt_reset_o; endproperty
  a_off: assert property (p_off) else $error("disabled timer active");
endmodule // wwdt_core_monitor

bind wwdt_core wwdt_core_monitor u_mon
(
  .core_clk_i              (core_clk_i),
  .reset_n_i               (reset_n_i),
  .option_byte_i           (option_byte_i),
  .internal_osc_mode_reg_i (internal_osc_mode_reg_i),
  .bus_addr_i              (bus_addr_i),
  .bus_wr_i                (bus_wr_i),
  .bus_bit_op_i            (bus_bit_op_i),
  .bus_wdata_i             (bus_wdata_i),
  .wdt_reset_o             (wdt_reset_o),
  .reset_cause_reg_o       (reset_cause_reg_o),
  .wdt_count_o             (wdt_count_o),
  .window_open_o           (window_open_o)
);

// ==== test/tb.sv ====
// Self-checking bench for the windowed watchdog core
`timescale 1ns/10ps
module tb;
  reg         core_clk_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg         cause_por_n_i = 1'b0;
  reg         lowspeed_clk_i = 1'b0;
  reg  [7:0]  option_byte_i = 8'h00;
  reg  [7:0]  internal_osc_mode_reg_i = 8'h00;
  reg         halt_mode_i = 1'b0;
  reg         stop_mode_i = 1'b0;
  reg  [15:0] bus_addr_i = 16'hFF99;
  reg         bus_wr_i = 1'b0;
  reg         bus_rd_i = 1'b0;
  reg         bus_bit_op_i = 1'b0;
  reg  [7:0]  bus_wdata_i = 8'h00;
  reg         cause_clr_i = 1'b0;
  wire [7:0]  bus_rdata_o;
  wire        wdt_reset_o;
  wire [7:0]  reset_cause_reg_o;
  wire [16:0] wdt_count_o;
  wire        window_open_o;
  wire        wdt_running_o;
  integer     error_cnt = 0;
  integer     num_checks = 0;
  integer     i;
  integer     k;
  reg  [16:0] held;
  reg  [2:0]  div_q = 3'h0;
  wwdt_core uut
  (
    .core_clk_i              (core_clk_i),
    .reset_n_i               (reset_n_i),
    .cause_por_n_i           (cause_por_n_i),
    .lowspeed_clk_i          (lowspeed_clk_i),
    .option_byte_i           (option_byte_i),
    .internal_osc_mode_reg_i (internal_osc_mode_reg_i),
    .halt_mode_i             (halt_mode_i),
    .stop_mode_i             (stop_mode_i),
    .bus_addr_i              (bus_addr_i),
    .bus_wr_i                (bus_wr_i),
    .bus_rd_i                (bus_rd_i),
    .bus_bit_op_i            (bus_bit_op_i),
    .bus_wdata_i             (bus_wdata_i),
    .cause_clr_i             (cause_clr_i),
    .bus_rdata_o             (bus_rdata_o),
    .wdt_reset_o             (wdt_reset_o),
    .reset_cause_reg_o       (reset_cause_reg_o),
    .wdt_count_o             (wdt_count_o),
    .window_open_o           (window_open_o),
    .wdt_running_o           (wdt_running_o)
  );
  always #10 core_clk_i = ~core_clk_i;
  // Low-speed clock at an eighth of the core rate keeps runs short
  always @(posedge core_clk_i)
  begin
    div_q <= div_q + 3'h1;
    lowspeed_clk_i <= div_q[2];
  end
  ////////////////////////////////////////
  task chk(input [16:0] got, input [16:0] exp, input [8*9:1] nm);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task rst(input [7:0] opt);
    begin
      @(posedge core_clk_i);
      reset_n_i <= 1'b0;
      option_byte_i <= opt;
      repeat (8) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      cause_por_n_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
    end
  endtask
  task acc(input wr, input bit_op, input [7:0] d);
    begin
      @(posedge core_clk_i);
      bus_wr_i <= wr;
      bus_rd_i <= !wr;
      bus_bit_op_i <= bit_op;
      bus_wdata_i <= d;
      @(posedge core_clk_i);
      bus_wr_i <= 1'b0;
      bus_rd_i <= 1'b0;
      bus_bit_op_i <= 1'b0;
      #1;
    end
  endtask
  // Bounded wait on reset request (sel 1) or open window (sel 0)
  task wt(input sel, input integer n);
    begin
      i = 0;
      while (i < n && (sel ? wdt_reset_o : window_open_o) !== 1'b1)
      begin
        @(posedge core_clk_i);
        #1;
        i = i + 1;
      end
      if (i >= n)
      begin
        error_cnt = error_cnt + 1;
        test_done;
      end
    end
  endtask
  ////////////////////////////////////////
  task sc_off;
    begin
      rst(8'h0E);
      acc(1'b0, 1'b0, 8'h00);
      chk(bus_rdata_o, 8'h1A, "rd_off");
      @(posedge core_clk_i);
      bus_addr_i <= 16'hFF98;
      acc(1'b0, 1'b0, 8'h00);
      chk(bus_rdata_o, 8'h00, "unmapped");
      bus_addr_i <= 16'hFF99;
      acc(1'b1, 1'b0, 8'h55);
      repeat (40) @(posedge core_clk_i);
      #1 chk(wdt_reset_o, 1'b0, "rst_off");
      chk(wdt_running_o, 1'b0, "run_off");
      chk(wdt_count_o, 17'h0_0000, "cnt_off");
    end
  endtask
  task sc_svc;
    begin
      rst(8'h70);
      acc(1'b0, 1'b0, 8'h00);
      chk(bus_rdata_o, 8'h9A, "rd_on");
      acc(1'b1, 1'b0, 8'hAC);
      chk(wdt_count_o, 1'b0, "first");
      repeat (100) @(posedge core_clk_i);
      #1 chk(wdt_count_o != 0, 1'b1, "counting");
      acc(1'b1, 1'b0, 8'hAC);
      chk(wdt_count_o, 1'b0, "key");
      acc(1'b0, 1'b0, 8'h00);
      chk(bus_rdata_o, 8'h9A, "rd_key");
      chk(wdt_reset_o, 1'b0, "no_rst");
      acc(1'b1, 1'b0, 8'h55);
      chk(wdt_reset_o, 1'b1, "bad_val");
      chk(reset_cause_reg_o, 8'h10, "cause");
    end
  endtask
  task sc_bit;
    begin
      rst(8'h70);
      chk(reset_cause_reg_o, 8'h10, "kept");
      cause_clr_i <= 1'b1;
      @(posedge core_clk_i);
      cause_clr_i <= 1'b0;
      #1 chk(reset_cause_reg_o, 8'h00, "cleared");
      acc(1'b1, 1'b1, 8'hAC);
      chk(wdt_reset_o, 1'b1, "bit_op");
      rst(8'h70);
      acc(1'b0, 1'b1, 8'h00);
      chk(wdt_reset_o, 1'b1, "bit_rd");
      chk(bus_rdata_o, 8'h00, "bit_data");
    end
  endtask
  task sc_win;
    begin
      rst(8'h12);
      acc(1'b1, 1'b0, 8'hAC);
      chk(wdt_reset_o, 1'b0, "first_rst");
      chk(wdt_count_o, 17'h0_0000, "first_cl");
      acc(1'b1, 1'b0, 8'hAC);
      chk(wdt_reset_o, 1'b1, "closed");
    end
  endtask
  task sc_thr;
    for (k = 0; k < 4; k = k + 1)
    begin
      rst({1'b0, k[1:0], 3'h4, k == 0, 1'b0});
      acc(1'b1, 1'b0, 8'hAC);
      wt(1'b0, 16000);
      chk(wdt_count_o, (k == 0) ? 17'h0_0600 : 17'h0_0100 * (3 - k), "open");
      acc(1'b1, 1'b0, 8'hAC);
      chk(wdt_reset_o, 1'b0, "open_rst");
      chk(wdt_count_o, 17'h0_0000, "open_key");
    end
  endtask
  task sc_hold;
    begin
      rst(8'h70);
      acc(1'b1, 1'b0, 8'hAC);
      for (k = 1; k < 4; k = k + 1)
      begin
        @(posedge core_clk_i);
        halt_mode_i <= k == 1;
        stop_mode_i <= k == 2;
        internal_osc_mode_reg_i <= {6'h00, k == 3, 1'b0};
        repeat (4) @(posedge core_clk_i);
        #1 held = wdt_count_o;
        if (k == 3)
          acc(1'b1, 1'b0, 8'h55);
        repeat (64) @(posedge core_clk_i);
        #1 chk(wdt_count_o, held, "held");
        chk(wdt_reset_o, 1'b0, "defer");
        chk(wdt_running_o, 1'b0, "paused");
        @(posedge core_clk_i);
        halt_mode_i <= 1'b0;
        stop_mode_i <= 1'b0;
        internal_osc_mode_reg_i <= 8'h00;
        if (k < 3)
        begin
          repeat (64) @(posedge core_clk_i);
          #1 chk(wdt_count_o > held, 1'b1, "resume");
          chk(wdt_running_o, 1'b1, "resumed");
        end
      end
      wt(1'b1, 4);
      chk(wdt_reset_o, 1'b1, "late_rst");
    end
  endtask
  task sc_ovf;
    begin
      rst(8'h71);
      cause_clr_i <= 1'b1;
      @(posedge core_clk_i);
      cause_clr_i <= 1'b0;
      #1 chk(reset_cause_reg_o, 8'h00, "pre_ovf");
      acc(1'b1, 1'b0, 8'hAC);
      @(posedge core_clk_i);
      halt_mode_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1 chk(wdt_running_o, 1'b1, "lock_run");
      wt(1'b1, 8400);
      chk(i > 8100, 1'b1, "ovf_time");
      chk(reset_cause_reg_o, 8'h10, "ovf_cause");
      @(posedge core_clk_i);
      halt_mode_i <= 1'b0;
    end
  endtask
  initial
  begin
    sc_off;
    sc_svc;
    sc_bit;
    sc_win;
    sc_thr;
    sc_hold;
    sc_ovf;
    test_done;
  end
endmodule // tb
